// ==== verilog/rtc_pkg.sv ====
package rtc_pkg;
    // control byte patterns, upper seven bits
    localparam logic [6:0] CTRL_RTC = 7'h6f;
    localparam logic [6:0] CTRL_EE = 7'h57;
    // address map
    localparam logic [7:0] RTC_BASE = 8'h00;
    localparam logic [7:0] RTC_TOP = 8'h1f;
    localparam logic [7:0] SRAM_BASE = 8'h20;
    localparam logic [7:0] SRAM_TOP = 8'h5f;
    localparam logic [7:0] EE_LOW = 8'hf0;
    localparam logic [7:0] EE_HIGH = 8'hf7;
    localparam logic [7:0] KEY_ADDR_DEF = 8'h09;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [7:0] EE_ERASED = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int RAM_WORDS = 96;
    localparam int EE_WORDS = 8;
    localparam int FIFO_DEPTH = 32;
    // bit counter marks
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_DONE = 4'h9;
    // timing
    localparam int CLK_MHZ = 25;
    localparam int EE_WRITE_TIME_US = 5000;
    // unlock progress
    localparam logic [1:0] KEY_NONE = 2'h0;
    localparam logic [1:0] KEY_HALF = 2'h1;
    localparam logic [1:0] KEY_ARMED = 2'h2;

    typedef enum logic [5:0]
    {
        ST_IDLE = 6'h01,
        ST_CTRL = 6'h02,
        ST_ADDR = 6'h04,
        ST_WDATA = 6'h08,
        ST_RDATA = 6'h10,
        ST_SKIP = 6'h20
    } rtc_state_t;

    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] data;
    } rtc_upd_t;

    typedef struct packed
    {
        logic scl;
        logic sda;
    } rtc_pin_in_t;

    typedef struct packed
    {
        logic scl_o;
        logic scl_oe_n;
        logic sda_o;
        logic sda_oe_n;
    } rtc_pin_out_t;
endpackage

// ==== verilog/rtc_fifo.sv ====
`timescale 1ns/10ps
module rtc_fifo import rtc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed
    {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } rtc_fifo_st_t;

    rtc_fifo_st_t q, d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic push, pop;

    assign in_ready = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_q[q.rd];

    always_comb
    begin
        d = q;
        if (push)
        begin
            d.wr = q.wr + 1'b1;
        end
        if (pop)
        begin
            d.rd = q.rd + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
        if (push)
        begin
            mem_q[q.wr] <= in_data;
        end
    end
endmodule

// ==== verilog/rtc_i2c_target.sv ====
// Notes on behaviour
// - pointer holds last accessed address plus one
// - read control byte: ack, send one byte
// - one pointer shared by both spaces
// - write address loads pointer before repeated start
// - random read leaves pointer after returned byte
// - master ack requests next byte, nack ends
// - reads wrap within clock or SRAM block
// - eeprom decoded only at F0-F7, own control
// - eeprom address outside range is not acked
// - eeprom reads need no unlock
// - key location has no storage, reads zero
// - keys 55 then AA arm eeprom writing
// - broken key order keeps eeprom locked
// - relock after any eeprom write command that accepted a data byte
// - timed write cycle after stop, eeprom nacked
// - clock and SRAM served during write cycle
// - bad eeprom write address: nack, store nothing
// - byte write leaves pointer after written byte
// - eight byte page, low three bits wrap
// - busy nacks eeprom control byte, ack when done
// - eeprom read wraps F7 to F0
// - clock 00-1F, SRAM 20-5F, shared control
// - clock/SRAM write above 5F nacked, unstored
`timescale 1ns/10ps
module rtc_i2c_target import rtc_pkg::*;
#(
    parameter logic [7:0] KEY_ADDR = KEY_ADDR_DEF,
    parameter int EE_WR_CYCLES = EE_WRITE_TIME_US * CLK_MHZ
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire rtc_pin_in_t bus_pins,
    output rtc_pin_out_t bus_drive,
    output rtc_upd_t upd_data,
    output logic upd_valid,
    input wire logic upd_ready,
    output logic ee_busy
);
    // ============================================================
    // state
    typedef struct packed
    {
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        rtc_state_t st;
        logic [3:0] bits;
        logic [7:0] sh;
        logic sda_drv;
        logic scl_drv;
        logic mack;
        logic ee;
        logic [7:0] ptr;
        logic [1:0] key;
        logic ee_wr;
        logic [EE_WORDS-1:0] pmask;
        logic busy;
        logic [23:0] tmr;
    } rtc_core_t;
    rtc_core_t q, d;
    logic [7:0] mem_q [RAM_WORDS];
    logic [7:0] page_q [EE_WORDS];
    logic [7:0] ee_q [EE_WORDS];
    logic scl_rise, scl_fall, start_c, stop_c;
    logic mem_we, page_we, ee_commit, push, fifo_ready;
    rtc_upd_t push_d;
    // ============================================================
    // decoding shared by several paths
    function automatic logic in_ee(input logic [7:0] p);
        return (p >= EE_LOW) && (p <= EE_HIGH);
    endfunction
    function automatic logic [7:0] ptr_next(input logic [7:0] p, input logic ee);
        if (ee)
        begin
            return {p[7:3], 3'(p[2:0] + 3'h1)};
        end
        if (p == RTC_TOP)
        begin
            return RTC_BASE;
        end
        if (p == SRAM_TOP)
        begin
            return SRAM_BASE;
        end
        return 8'(p + 8'h01);
    endfunction
    function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic ee);
        if (ee)
        begin
            return in_ee(p) ? ee_q[p[2:0]] : ZERO_BYTE;
        end
        if ((p == KEY_ADDR) || (p > SRAM_TOP))
        begin
            return ZERO_BYTE;
        end
        return mem_q[p[6:0]];
    endfunction
    // ============================================================
    // bus conditions, from the synchronised copies only
    assign scl_rise = q.scl_s & ~q.scl_p;
    assign scl_fall = ~q.scl_s & q.scl_p;
    assign start_c = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    assign stop_c = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    always_comb
    begin
        d = q;
        mem_we = 1'b0;
        page_we = 1'b0;
        ee_commit = 1'b0;
        push = 1'b0;
        push_d = '{addr: q.ptr, data: q.sh};
        d.scl_m = bus_pins.scl;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = bus_pins.sda;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        // internally timed programming runs beside bus traffic
        if (q.busy)
        begin
            if (q.tmr == '0)
            begin
                d.busy = 1'b0;
                ee_commit = 1'b1;
                d.pmask = '0;
            end
            else
            begin
                d.tmr = q.tmr - 24'h000001;
            end
        end
        if (start_c || stop_c)
        begin
            if (q.ee_wr)
            begin
                d.key = KEY_NONE;
                d.ee_wr = 1'b0;
                if (stop_c)
                begin
                    d.busy = 1'b1;
                    d.tmr = 24'(EE_WR_CYCLES - 1);
                end
                else
                begin
                    // page only reaches the array on a stop
                    d.pmask = '0;
                end
            end
            d.st = start_c ? ST_CTRL : ST_IDLE;
            d.bits = '0;
            d.sda_drv = 1'b0;
            d.scl_drv = 1'b0;
        end
        else if (scl_fall && (q.bits == BIT_DONE))
        begin
            // end of the ninth clock: release, then start any byte out
            d.sda_drv = 1'b0;
            d.bits = '0;
            if (q.st == ST_RDATA)
            begin
                if (q.mack)
                begin
                    d.sh = rd_byte(q.ptr, q.ee);
                    d.sda_drv = ~d.sh[7];
                    d.ptr = ptr_next(q.ptr, q.ee);
                end
                else
                begin
                    d.st = ST_SKIP;
                end
            end
        end
        else
        begin
            case (q.st)
                ST_CTRL, ST_ADDR, ST_WDATA:
                begin
                    if (scl_rise && (q.bits < BIT_ACK))
                    begin
                        d.sh = {q.sh[6:0], q.sda_s};
                        d.bits = 4'(q.bits + 4'h1);
                    end
                    else if (!q.scl_s && (q.bits == BIT_ACK))
                    begin
                        d.bits = BIT_DONE;
                        d.sda_drv = 1'b0;
                        d.scl_drv = 1'b0;
                        case (q.st)
                            ST_CTRL:
                            begin
                                if ((q.sh[7:1] == CTRL_RTC) ||
                                    ((q.sh[7:1] == CTRL_EE) && !q.busy))
                                begin
                                    d.sda_drv = 1'b1;
                                    d.ee = (q.sh[7:1] == CTRL_EE);
                                    d.st = q.sh[0] ? ST_RDATA : ST_ADDR;
                                    d.mack = 1'b1;
                                end
                            end
                            ST_ADDR:
                            begin
                                if (q.ee ? in_ee(q.sh) : (q.sh <= SRAM_TOP))
                                begin
                                    d.sda_drv = 1'b1;
                                    d.ptr = q.sh;
                                    d.st = ST_WDATA;
                                end
                            end
                            default:
                            begin
                                if (q.ee)
                                begin
                                    if (q.key == KEY_ARMED)
                                    begin
                                        d.sda_drv = 1'b1;
                                        page_we = 1'b1;
                                        d.pmask[q.ptr[2:0]] = 1'b1;
                                        d.ptr = ptr_next(q.ptr, 1'b1);
                                        d.ee_wr = 1'b1;
                                    end
                                end
                                else if (q.ptr == KEY_ADDR)
                                begin
                                    d.sda_drv = 1'b1;
                                    if (q.sh == KEY_FIRST)
                                    begin
                                        d.key = KEY_HALF;
                                    end
                                    else if ((q.key == KEY_HALF) && (q.sh == KEY_SECOND))
                                    begin
                                        d.key = KEY_ARMED;
                                    end
                                    else
                                    begin
                                        d.key = KEY_NONE;
                                    end
                                    d.ptr = ptr_next(q.ptr, 1'b0);
                                end
                                else if (!fifo_ready)
                                begin
                                    // hold scl low until the update fifo has room for one more entry
                                    d.bits = BIT_ACK;
                                    d.scl_drv = 1'b1;
                                end
                                else
                                begin
                                    d.sda_drv = 1'b1;
                                    mem_we = 1'b1;
                                    push = 1'b1;
                                    d.key = KEY_NONE;
                                    d.ptr = ptr_next(q.ptr, 1'b0);
                                end
                            end
                        endcase
                        if (!d.sda_drv && !d.scl_drv)
                        begin
                            d.st = ST_SKIP;
                        end
                    end
                end
                ST_RDATA:
                begin
                    if (scl_rise)
                    begin
                        if (q.bits < BIT_ACK)
                        begin
                            d.bits = 4'(q.bits + 4'h1);
                        end
                        else
                        begin
                            d.mack = ~q.sda_s;
                            d.bits = BIT_DONE;
                        end
                    end
                    else if (scl_fall)
                    begin
                        if (q.bits == BIT_ACK)
                        begin
                            d.sda_drv = 1'b0;
                        end
                        else
                        begin
                            d.sh = {q.sh[6:0], 1'b0};
                            d.sda_drv = ~q.sh[6];
                        end
                    end
                end
                ST_IDLE, ST_SKIP:
                begin
                    d.sda_drv = 1'b0;
                end
                default:
                begin
                    d.st = ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // registers and storage
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            q <= '0;
            q.scl_m <= 1'b1;
            q.scl_s <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_m <= 1'b1;
            q.sda_s <= 1'b1;
            q.sda_p <= 1'b1;
            q.st <= ST_IDLE;
        end
        else
        begin
            q <= d;
        end
        // sram is deliberately left uninitialised by reset
        if (mem_we)
        begin
            mem_q[q.ptr[6:0]] <= q.sh;
        end
        if (page_we)
        begin
            page_q[q.ptr[2:0]] <= q.sh;
        end
    end
    for (genvar i = 0; i < EE_WORDS; i++)
    begin : g_ee
        always_ff @(posedge clk_sys)
        begin
            if (rst)
            begin
                ee_q[i] <= EE_ERASED;
            end
            else if (ee_commit && q.pmask[i])
            begin
                ee_q[i] <= page_q[i];
            end
        end
    end
    rtc_fifo #(.WIDTH($bits(rtc_upd_t)), .DEPTH(FIFO_DEPTH)) u_upd_fifo
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(push_d),
        .out_valid(upd_valid),
        .out_ready(upd_ready),
        .out_data(upd_data)
    );
    assign bus_drive = '{scl_o: 1'b0, scl_oe_n: ~q.scl_drv, sda_o: 1'b0, sda_oe_n: ~q.sda_drv};
    assign ee_busy = q.busy;
endmodule

// ==== tb/rtc_i2c_target_properties.sv ====
`timescale 1ns/10ps
module rtc_i2c_target_properties import rtc_pkg::*;
#(
    parameter logic [7:0] KEY_ADDR = KEY_ADDR_DEF,
    parameter int EE_WR_CYCLES = EE_WRITE_TIME_US * CLK_MHZ
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire rtc_pin_in_t bus_pins,
    input wire rtc_pin_out_t bus_drive,
    input wire rtc_upd_t upd_data,
    input wire logic upd_valid,
    input wire logic upd_ready,
    input wire logic ee_busy
);
    // ====================
    // helpers
    int busy_q;
    always_ff @(posedge clk_sys)
    begin
        busy_q <= (rst || !ee_busy) ? 0 : busy_q + 1;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_stop;
        bus_pins.scl && $rose(bus_pins.sda);
    endsequence
    sequence s_busy_start;
        $rose(ee_busy);
    endsequence
    // ====================
    // properties
    property p_reset;
        disable iff (1'b0)
        rst |=> bus_drive.sda_oe_n && bus_drive.scl_oe_n && !upd_valid && !ee_busy;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not idle after reset");
    property p_open_drain;
        bus_drive.scl_o == 1'b0 && bus_drive.sda_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("pin drive value not low");
    property p_release;
        s_stop |-> ##[1:5] bus_drive.sda_oe_n;
    endproperty
    a_release: assert property (p_release)
        else $error("sda still driven after stop");
    property p_busy_len;
        $fell(ee_busy) |-> busy_q == EE_WR_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("write cycle length wrong");
    property p_busy_hold;
        s_busy_start |-> ee_busy [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("write cycle dropped early");
    property p_busy_at_stop;
        s_busy_start |-> bus_pins.scl && bus_pins.sda;
    endproperty
    a_busy_at_stop: assert property (p_busy_at_stop)
        else $error("write cycle began outside stop");
    property p_stretch;
        !bus_drive.scl_oe_n |-> upd_valid;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("clock held with empty queue");
    property p_fifo_hold;
        upd_valid && !upd_ready |=> upd_valid && $stable(upd_data);
    endproperty
    a_fifo_hold: assert property (p_fifo_hold)
        else $error("queue head changed while stalled");
    property p_upd_range;
        upd_valid |-> upd_data.addr <= SRAM_TOP && upd_data.addr != KEY_ADDR;
    endproperty
    a_upd_range: assert property (p_upd_range)
        else $error("update for unstorable address");
endmodule

// ==== tb/rtc_i2c_master.sv ====
`timescale 1ns/10ps
module rtc_i2c_master
(
    input wire logic clk_sys,
    input wire logic scl,
    input wire logic sda,
    output logic scl_m,
    output logic sda_m
);
    // ====================
    // bus phases, quarter link period each
    initial
    begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    task automatic q();
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic bit_x(input logic b, output logic r);
        scl_m = 1'b0;
        q();
        sda_m = b;
        q();
        scl_m = 1'b1;
        q();
        // a stretching target keeps the wire low
        while (!scl)
            @(negedge clk_sys);
        r = sda;
        q();
    endtask
    task automatic start();
        scl_m = 1'b0;
        // extra wait lets a target ack drive drop first
        q();
        q();
        sda_m = 1'b1;
        q();
        scl_m = 1'b1;
        q();
        sda_m = 1'b0;
        q();
    endtask
    task automatic stop();
        scl_m = 1'b0;
        q();
        sda_m = 1'b0;
        q();
        scl_m = 1'b1;
        q();
        sda_m = 1'b1;
        q();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(last, r);
    endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench import rtc_pkg::*;;
    localparam int EWC = 1200;
    localparam logic [7:0] WC = {CTRL_RTC, 1'b0};
    localparam logic [7:0] EW = {CTRL_EE, 1'b0};
    localparam logic [7:0] ER = {CTRL_EE, 1'b1};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic upd_ready = 1'b0;
    logic scl_m;
    logic sda_m;
    logic upd_valid;
    logic ee_busy;
    logic ack;
    rtc_pin_in_t bus_pins;
    rtc_pin_out_t bus_drive;
    rtc_upd_t upd_data;
    int n_errors = 0;
    int checked = 0;
    logic [7:0] rows [4][2] = '{'{8'h00, 8'h12}, '{8'h1f, 8'h34}, '{8'h20, 8'h56},
        '{8'h5f, 8'h78}};
    always #20 clk_sys = ~clk_sys;
    // pull-ups: an undriven enable counts as released
    assign bus_pins = '{scl: scl_m & (bus_drive.scl_oe_n !== 1'b0),
        sda: sda_m & (bus_drive.sda_oe_n !== 1'b0)};
    rtc_i2c_target #(.KEY_ADDR(KEY_ADDR_DEF), .EE_WR_CYCLES(EWC)) i_rtc_i2c_target
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .bus_pins(bus_pins),
        .bus_drive(bus_drive),
        .upd_data(upd_data),
        .upd_valid(upd_valid),
        .upd_ready(upd_ready),
        .ee_busy(ee_busy)
    );
    rtc_i2c_master i_rtc_i2c_master
    (
        .clk_sys(clk_sys),
        .scl(bus_pins.scl),
        .sda(bus_pins.sda),
        .scl_m(scl_m),
        .sda_m(sda_m)
    );
    // ====================
    // tasks
    task automatic chk1(input string s, input logic e, input logic g);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic w(input logic [7:0] d, input logic e);
        logic a;
        i_rtc_i2c_master.wbyte(d, a);
        chk1("ack", e, a);
    endtask
    task automatic r(input logic last, input logic [7:0] e);
        logic [7:0] d;
        i_rtc_i2c_master.rbyte(last, d);
        chk8("rdata", e, d);
    endtask
    task automatic wr1(input logic [7:0] c, a, d, input logic ea, ed);
        i_rtc_i2c_master.start();
        w(c, 1'b1);
        w(a, ea);
        w(d, ed);
        i_rtc_i2c_master.stop();
    endtask
    task automatic seek(input logic [7:0] c, a);
        i_rtc_i2c_master.start();
        w(c, 1'b1);
        w(a, 1'b1);
        i_rtc_i2c_master.start();
        w(c | 8'h01, 1'b1);
    endtask
    task automatic rd1(input logic [7:0] c, a, e);
        seek(c, a);
        r(1'b1, e);
        i_rtc_i2c_master.stop();
    endtask
    task automatic cur(input logic [7:0] c, e);
        i_rtc_i2c_master.start();
        w(c | 8'h01, 1'b1);
        r(1'b1, e);
        i_rtc_i2c_master.stop();
    endtask
    task automatic pop(input logic [7:0] a, d);
        chk1("upd_valid", 1'b1, upd_valid);
        chk8("upd_addr", a, upd_data.addr);
        chk8("upd_data", d, upd_data.data);
        upd_ready = 1'b1;
        @(negedge clk_sys);
        upd_ready = 1'b0;
    endtask
    task automatic final_report();
        if (n_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ====================
    // sequence
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        n_errors++;
        final_report();
    end
    initial
    begin
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk1("ee_busy", 1'b0, ee_busy);
        rd1(EW, EE_LOW, EE_ERASED);
        foreach (rows[i])
        begin
            wr1(WC, rows[i][0], rows[i][1], 1'b1, 1'b1);
            pop(rows[i][0], rows[i][1]);
            rd1(WC, rows[i][0], rows[i][1]);
        end
        cur(WC, 8'h56);
        seek(WC, RTC_TOP);
        r(1'b0, 8'h34);
        r(1'b1, 8'h12);
        i_rtc_i2c_master.stop();
        wr1(WC, 8'h60, 8'h99, 1'b0, 1'b0);
        chk1("upd_valid", 1'b0, upd_valid);
        rd1(WC, KEY_ADDR_DEF, ZERO_BYTE);
        wr1(EW, 8'hef, 8'h01, 1'b0, 1'b0);
        wr1(WC, KEY_ADDR_DEF, KEY_SECOND, 1'b1, 1'b1);
        wr1(WC, KEY_ADDR_DEF, KEY_FIRST, 1'b1, 1'b1);
        wr1(EW, 8'hf3, 8'h11, 1'b1, 1'b0);
        chk1("ee_busy", 1'b0, ee_busy);
        wr1(WC, KEY_ADDR_DEF, KEY_FIRST, 1'b1, 1'b1);
        wr1(WC, KEY_ADDR_DEF, KEY_SECOND, 1'b1, 1'b1);
        chk1("upd_valid", 1'b0, upd_valid);
        i_rtc_i2c_master.start();
        w(EW, 1'b1);
        w(8'hf6, 1'b1);
        for (int i = 0; i < 10; i++)
            w(8'h80 | 8'(i), 1'b1);
        i_rtc_i2c_master.stop();
        repeat (6) @(negedge clk_sys);
        chk1("ee_busy", 1'b1, ee_busy);
        // a busy device refuses the control byte itself
        i_rtc_i2c_master.start();
        w(EW, 1'b0);
        w(EE_LOW, 1'b0);
        w(8'h00, 1'b0);
        i_rtc_i2c_master.stop();
        wr1(WC, 8'h30, 8'h5a, 1'b1, 1'b1);
        pop(8'h30, 8'h5a);
        rd1(WC, 8'h30, 8'h5a);
        ack = 1'b0;
        // bounded polling, gives up after 30 tries
        for (int k = 0; k < 30 && !ack; k++)
        begin
            i_rtc_i2c_master.start();
            i_rtc_i2c_master.wbyte(EW, ack);
            i_rtc_i2c_master.stop();
        end
        chk1("poll_ack", 1'b1, ack);
        chk1("ee_busy", 1'b0, ee_busy);
        wr1(EW, EE_LOW, 8'h00, 1'b1, 1'b0);
        seek(EW, 8'hf6);
        r(1'b0, 8'h88);
        r(1'b0, 8'h89);
        r(1'b1, 8'h82);
        i_rtc_i2c_master.stop();
        rd1(WC, SRAM_BASE, 8'h56);
        cur(ER, ZERO_BYTE);
        i_rtc_i2c_master.start();
        w(WC, 1'b1);
        w(SRAM_BASE, 1'b1);
        fork
            for (int i = 0; i < 33; i++)
                w(8'(i), 1'b1);
            begin
                repeat (3000) @(negedge clk_sys);
                chk1("scl_hold", 1'b0, bus_drive.scl_oe_n);
                pop(SRAM_BASE, 8'h00);
            end
        join
        i_rtc_i2c_master.stop();
        upd_ready = 1'b1;
        repeat (40) @(negedge clk_sys);
        chk1("upd_valid", 1'b0, upd_valid);
        // mid-run reset: pointer back to zero, sram kept
        rst = 1'b1;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk1("ee_busy", 1'b0, ee_busy);
        cur(WC, 8'h12);
        final_report();
    end
endmodule
bind rtc_i2c_target rtc_i2c_target_properties
    #(.KEY_ADDR(KEY_ADDR), .EE_WR_CYCLES(EE_WR_CYCLES)) i_rtc_i2c_target_properties
(
    .clk_sys(clk_sys),
    .rst(rst),
    .bus_pins(bus_pins),
    .bus_drive(bus_drive),
    .upd_data(upd_data),
    .upd_valid(upd_valid),
    .upd_ready(upd_ready),
    .ee_busy(ee_busy)
);
